// ---- sim/meas_source.sv ----
// measurement channels and breaker objects around the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "synchrocheck_defines.vh"
module meas_source (
	// clock
	input  wire logic                        clk,
	// aux channel a values
	input  wire logic [15:0]                 auxMag,
	input  wire logic [19:0]                 auxAng,
	input  wire logic [19:0]                 auxFrq,
	// channel values
	output logic      [`NUM_CHAN*`MAG_W-1:0] measMag,
	output logic      [`NUM_CHAN*`ANG_W-1:0] measAng,
	output logic      [`NUM_CHAN*`FRQ_W-1:0] measFrq,
	// breaker objects
	input  wire logic [4:0]                  closeCmd,
	output logic      [7:0]                  closeCount,
	output logic      [4:0]                  lastObj
);
	// system channels at nominal level, 50 Hz, zero angle
	always_comb begin
		for (int i = 0; i < `NUM_CHAN; i++) begin
			measMag[i*16 +: 16] = (i == 6) ? auxMag : 16'h2710;
			measAng[i*20 +: 20] = (i == 6) ? auxAng : 20'h00000;
			measFrq[i*20 +: 20] = (i == 6) ? auxFrq : 20'h0c350;
		end
	end
	initial closeCount = 8'h00;
	initial lastObj = 5'h00;
	always @(posedge clk) begin
		if (closeCmd != 5'h00) begin
			closeCount <= closeCount + 8'h01;
			lastObj <= closeCmd;
		end
	end
endmodule
`default_nettype wire

// ---- sim/voltage_synchrocheck_chk.sv ----
// port assertions of the synchrocheck supervisor
`timescale 1ns/1ps
`default_nettype none
module voltage_synchrocheck_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// register bus
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// stage and breaker
	input wire logic [2:0] blockIn,
	input wire logic [2:0] stageOk,
	input wire logic [2:0] stageBlocked,
	input wire logic [4:0] closeCmd
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire req = wb_cyc_i & wb_stb_i;
	AST_ACK_ANSWER: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	AST_OK_BLK_EXCL: assert property ((stageOk & stageBlocked) == 3'h0)
		else $error("stage ok and blocked together");
	AST_BLOCK_CLEARS_OK: assert property (
		$rose(blockIn[0]) && stageOk[0] ##1 blockIn[0] |=> !stageOk[0])
		else $error("block did not clear ok in two cycles");
	AST_CLOSE_ONEHOT: assert property ($onehot0(closeCmd))
		else $error("close to more than one object");
	AST_CLOSE_PULSE: assert property (
		closeCmd != 5'h00 |=> closeCmd == 5'h00)
		else $error("close longer than one cycle");
	AST_CLOSE_BLOCKED: assert property (
		blockIn[0] [*3] |=> closeCmd == 5'h00)
		else $error("close while stage one blocked");
	AST_RESET_CLEARS: assert property (disable iff (1'b0)
		reset |=> stageOk == 3'h0 && stageBlocked == 3'h0 && closeCmd == 5'h00)
		else $error("outputs not cleared by reset");
	COV_OK: cover property (stageOk[0]);
	COV_BLOCKED: cover property (stageBlocked[0] && blockIn[0]);
	COV_CLOSE: cover property (closeCmd != 5'h00);
endmodule
`default_nettype wire

// ---- sim/voltage_synchrocheck_tb.sv ----
// self-checking bench of the synchrocheck supervisor
`timescale 1ns/1ps
`default_nettype none
`include "synchrocheck_defines.vh"
module voltage_synchrocheck_tb;
	localparam int TICKS = 20;
	logic                        clk, reset, wbCyc, wbStb, wbWe, wbAck;
	logic [7:0]                  wbAdr;
	logic [3:0]                  wbSel;
	logic [31:0]                 wbDatI, wbDatO, rd;
	logic [`NUM_CHAN*`MAG_W-1:0] measMag;
	logic [`NUM_CHAN*`ANG_W-1:0] measAng;
	logic [`NUM_CHAN*`FRQ_W-1:0] measFrq;
	logic [15:0]                 auxMag;
	logic [19:0]                 auxAng, auxFrq;
	logic [2:0]                  blockIn, stageStart, stageOk, stageBlocked;
	logic [4:0]                  closeCmd, lastObj;
	logic [7:0]                  closeCount;
	int                          errCount = 0;
	int                          checks = 0;
	voltage_synchrocheck #(.TICK_CYCLES(TICKS)) dut_u (.clk(clk),
		.reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .measMag(measMag),
		.measAng(measAng), .measFrq(measFrq), .blockIn(blockIn),
		.stageStart(stageStart), .stageOk(stageOk),
		.stageBlocked(stageBlocked), .closeCmd(closeCmd));
	meas_source src_u (.clk(clk), .auxMag(auxMag), .auxAng(auxAng),
		.auxFrq(auxFrq), .measMag(measMag), .measAng(measAng),
		.measFrq(measFrq), .closeCmd(closeCmd), .closeCount(closeCount),
		.lastObj(lastObj));
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
		input string what);
		bus(1'b0, a, 32'h0);
		check(what, e, rd);
	endtask
	task automatic waitTicks(input int n);
		repeat (n * TICKS) @(posedge clk);
	endtask
	task automatic okIs(input logic [2:0] e);
		check("stageOk", {29'h0, e}, {29'h0, stageOk});
	endtask
	task automatic tHidden;
		rdChk(`REG_CTRL, 32'h0, "ctrl reset");
		bus(1'b1, `REG_REFSEL, 32'h1);
		rdChk(`REG_REFSEL, 32'h0, "refsel hidden");
	endtask
	task automatic tDefaults;
		bus(1'b1, `REG_CTRL, 32'h1);
		rdChk(`REG_BRKTIME, 32'h0000000a, "brk time");
		rdChk(8'h10, 32'h0, "cond");
		rdChk(8'h14, 32'h07d007d0, "live dead");
		rdChk(8'h18, 32'h012c00c8, "udiff anglim");
		rdChk(8'h1c, 32'h0000000a, "flim");
		rdChk(8'h80, 32'h0, "unmapped");
	endtask
	task automatic tSync;
		bus(1'b1, `REG_CTRL, 32'h00004101);
		bus(1'b1, `REG_REFSEL, 32'h1);
		waitTicks(4);
		okIs(3'b001);
		check("closes", 32'h1, {24'h0, closeCount});
		check("object", 32'h1, {27'h0, lastObj});
		rdChk(`REG_ANGLE, 32'h000003e8, "angle");
		rdChk(`REG_ROTTIME, 32'h00000fa0, "rotation");
		rdChk(`REG_ESTTIME, 32'h00000f8a, "estimate");
		rdChk(`REG_STATUS, 32'h016b1001, "status");
	endtask
	task automatic tBlock;
		@(posedge clk);
		blockIn <= 3'b001;
		repeat (3) @(posedge clk);
		okIs(3'b000);
		waitTicks(1);
		check("blocked", 32'h1, {29'h0, stageBlocked});
		blockIn <= 3'b000;
		waitTicks(2);
		okIs(3'b001);
	endtask
	task automatic tMag;
		@(posedge clk);
		auxMag <= 16'h2836;
		waitTicks(2);
		okIs(3'b000);
		bus(1'b1, `REG_CTRL, 32'h00024101);
		bus(1'b1, 8'h18, 32'h012c0190);
		waitTicks(2);
		okIs(3'b001);
		check("closes", 32'h2, {24'h0, closeCount});
		check("object", 32'h4, {27'h0, lastObj});
		auxMag <= 16'h2710;
		bus(1'b1, 8'h18, 32'h012c00c8);
	endtask
	task automatic tGate;
		bus(1'b1, `REG_CTRL, 32'h00024901);
		waitTicks(2);
		okIs(3'b000);
		stageStart <= 3'b001;
		waitTicks(2);
		okIs(3'b001);
	endtask
	task automatic tForce;
		bus(1'b1, `REG_CTRL, 32'h00024115);
		waitTicks(1);
		okIs(3'b000);
		check("forced blk", 32'h1, {29'h0, stageBlocked});
		bus(1'b1, `REG_CTRL, 32'h00024345);
		waitTicks(2);
		okIs(3'b011);
	endtask
	task automatic tSides;
		bus(1'b1, `REG_CTRL, 32'h00000101);
		auxMag <= 16'h0100;
		waitTicks(2);
		rdChk(`REG_STATUS, 32'h016a0000, "dead bus");
		bus(1'b1, `REG_CTRL, 32'h00000181);
		waitTicks(2);
		rdChk(`REG_STATUS, 32'h01690000, "dead line");
		auxMag <= 16'h2710;
		bus(1'b1, `REG_CTRL, 32'h00200703);
		bus(1'b1, `REG_REFSEL, 32'h00000111);
		waitTicks(2);
		okIs(3'b111);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#200000;
		errCount++;
		finish_test();
	end
	initial begin
		reset = 1'b1;
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
		wbSel = 4'hf;
		auxMag = 16'h2710;
		auxAng = 20'h003e8;
		auxFrq = 20'h0c382;
		blockIn = 3'b000;
		stageStart = 3'b000;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		tHidden();
		tDefaults();
		tSync();
		tBlock();
		tMag();
		tGate();
		tForce();
		tSides();
		finish_test();
	end
endmodule
bind voltage_synchrocheck voltage_synchrocheck_chk chk_u (.clk(clk),
	.reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .blockIn(blockIn), .stageOk(stageOk),
	.stageBlocked(stageBlocked), .closeCmd(closeCmd));
`default_nettype wire

// ---- verilog/syn_stage.v ----
// one supervision stage: side classes, matching, ok and blocked
`timescale 1ns/1ps
`default_nettype none
`include "synchrocheck_defines.vh"
module syn_stage (
	// clock and reset
	input  wire                     clk,
	input  wire                     reset,
	// control
	input  wire                     evalTick,
	input  wire                     active,
	input  wire                     blockIn,
	input  wire                     lineIsMeas,
	input  wire [`COND_W-1:0]       condSel,
	input  wire [`MAG_W-1:0]        liveLim,
	input  wire [`MAG_W-1:0]        deadLim,
	input  wire [`MAG_W-1:0]        uDiffLim,
	input  wire [`MAG_W-1:0]        angLim,
	input  wire [`MAG_W-1:0]        fLim,
	// compared channels
	input  wire [`MAG_W-1:0]        measMag,
	input  wire [`MAG_W-1:0]        refMag,
	input  wire [`ANG_W-1:0]        measAng,
	input  wire [`ANG_W-1:0]        refAng,
	input  wire [`FRQ_W-1:0]        measFrq,
	input  wire [`FRQ_W-1:0]        refFrq,
	// results
	output reg                      ok,
	output reg                      blocked,
	output reg                      bypass,
	output reg                      ready,
	output reg  [2:0]               voltStat,
	output reg  signed [`ANG_W-1:0] angDiff,
	output reg  signed [`FRQ_W-1:0] frqDiff
);
	function [1:0] classify;
		input [`MAG_W-1:0] m;
		input [`MAG_W-1:0] lv;
		input [`MAG_W-1:0] dd;
		begin
			if (m > lv)
				classify = `CLS_LIVE;
			else if (dd != {`MAG_W{1'b0}} && m < dd)
				classify = `CLS_DEAD;
			else
				classify = `CLS_UNDEF;
		end
	endfunction

	// bit n permits voltage state n, top bit is bypass
	function [4:0] permitMask;
		input [`COND_W-1:0] c;
		begin
			case (c)
			4'h0: permitMask = 5'h08;
			4'h1: permitMask = 5'h02;
			4'h2: permitMask = 5'h04;
			4'h3: permitMask = 5'h0a;
			4'h4: permitMask = 5'h0c;
			4'h5: permitMask = 5'h09;
			4'h6: permitMask = 5'h0e;
			4'h7: permitMask = 5'h0b;
			4'h8: permitMask = 5'h0d;
			4'h9: permitMask = 5'h10;
			default: permitMask = 5'h00;
			endcase
		end
	endfunction

	wire signed [`ANG_W:0]   rawAng;
	wire signed [`FRQ_W:0]   rawFrq;
	reg  signed [`ANG_W:0]   wrapAng;
	wire [`ANG_W:0]          absAng;
	wire [`FRQ_W:0]          absFrq;
	wire [`MAG_W-1:0]        magDiff;
	wire [`ANG_W-1:0]        angLimS;
	wire [`FRQ_W-1:0]        fLimS;
	wire [1:0]               clsBus;
	wire [1:0]               clsLine;
	wire [4:0]               perm;
	reg  [2:0]               vs;
	wire                     permitted;
	wire                     magOk;
	wire                     angOk;
	wire                     frqOk;

	assign rawAng  = {measAng[`ANG_W-1], measAng} - {refAng[`ANG_W-1], refAng};
	assign rawFrq  = {1'b0, measFrq} - {1'b0, refFrq};
	assign absAng  = wrapAng[`ANG_W] ? -wrapAng : wrapAng;
	assign absFrq  = rawFrq[`FRQ_W] ? -rawFrq : rawFrq;
	assign magDiff = (measMag > refMag) ? measMag - refMag : refMag - measMag;
	assign angLimS = {4'h0, angLim} * `LIM_SCALE;
	assign fLimS   = {4'h0, fLim} * `LIM_SCALE;
	assign clsBus  = classify(lineIsMeas ? refMag : measMag, liveLim, deadLim);
	assign clsLine = classify(lineIsMeas ? measMag : refMag, liveLim, deadLim);
	assign perm    = permitMask(condSel);
	assign magOk   = magDiff < uDiffLim;
	assign angOk   = absAng < {1'b0, angLimS};
	assign frqOk   = absFrq < {1'b0, fLimS};
	// bypass passes any state; without bypass, undefined never passes
	assign permitted = perm[`PERM_BYPASS] | (~vs[2] & perm[vs[1:0]]);

	always @* begin
		wrapAng = rawAng;
		if (rawAng > $signed(`ANG_HALF))
			wrapAng = rawAng - ($signed(`ANG_HALF) + $signed(`ANG_HALF));
		else if (rawAng < -$signed(`ANG_HALF))
			wrapAng = rawAng + ($signed(`ANG_HALF) + $signed(`ANG_HALF));
	end

	// bit0 bus live, bit1 line live
	always @* begin
		if (clsBus == `CLS_UNDEF || clsLine == `CLS_UNDEF)
			vs = `VS_UNDEF;
		else
			vs = {1'b0, clsLine == `CLS_LIVE, clsBus == `CLS_LIVE};
	end

	always @(posedge clk) begin
		if (reset || !active) begin
			ok       <= 1'b0;
			blocked  <= 1'b0;
			bypass   <= 1'b0;
			ready    <= 1'b0;
			voltStat <= `VS_NOTMON;
			angDiff  <= {`ANG_W{1'b0}};
			frqDiff  <= {`FRQ_W{1'b0}};
		end else if (evalTick) begin
			voltStat <= vs;
			angDiff  <= wrapAng[`ANG_W-1:0];
			frqDiff  <= rawFrq[`FRQ_W-1:0];
			bypass   <= perm[`PERM_BYPASS];
			ready    <= permitted & magOk & frqOk;
			// block sampled here, once per cycle
			ok       <= permitted & magOk & angOk & frqOk & ~blockIn;
			blocked  <= permitted & magOk & angOk & frqOk & blockIn;
		end else if (ok && blockIn) begin
			ok      <= 1'b0;
			blocked <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/synchrocheck_defines.vh ----
// shared constants of the synchrocheck supervisor
`ifndef SYNCHROCHECK_DEFINES_VH
`define SYNCHROCHECK_DEFINES_VH
// timing: measurement period, also the breaker time step
`define CLK_FREQ_MHZ    25
`define MEAS_PERIOD_US  5000
`define TICK_W          17
// widths
`define MAG_W           16
`define ANG_W           20
`define FRQ_W           20
`define TIME_W          19
`define COND_W          4
`define NUM_CHAN        8
// channel slots: 0..2 phase pairs, 3..5 phase-earth, 6..7 aux
`define CH_AUX_A        3'h6
`define CH_AUX_B        3'h7
// register byte offsets
`define REG_CTRL        8'h00
`define REG_REFSEL      8'h04
`define REG_BRKTIME     8'h08
`define REG_STATUS      8'h40
`define REG_ESTTIME     8'h44
`define REG_ROTTIME     8'h48
`define REG_ANGLE       8'h4c
// stage pages at 0x10/0x20/0x30
`define ADR_PAGE        7:6
`define ADR_STG         5:4
`define ADR_FLD         3:2
`define PAGE_STAGE      2'h0
`define STG_NONE        2'h0
`define STG_FIRST       2'h1
`define STG_COND        2'h0
`define STG_LEVEL       2'h1
`define STG_DIFF        2'h2
`define STG_FDIFF       2'h3
`define LO_HALF         15:0
`define HI_HALF         31:16
// control bits
`define CTRL_AUXA_SS    0
`define CTRL_AUXB_SS    1
`define CTRL_FORCE_EN   2
`define CTRL_FORCE      6:4
`define CTRL_MEAS_LINE  7
`define CTRL_EN_LSB     8
`define CTRL_GATE_LSB   11
`define CTRL_SWITCH_EN  14
`define CTRL_OBJ        18:16
`define CTRL_PE_AVAIL   20
`define CTRL_TWO_AUX    21
`define CTRL_MASK       32'h003f7fff
`define REFSEL_W        9
`define REF1            2:0
`define REF2            5:4
`define REF3_BIT        8
// stage one reference codes
`define REF_NONE        3'h0
`define REF_PP_LAST     3'h3
`define REF_PE_LAST     3'h6
// reset values
`define CTRL_RESET      32'h00000000
`define REFSEL_RESET    9'h000
`define BRK_RESET       19'h0000a
`define COND_RESET      4'h0
`define LIVE_RESET      16'h07d0
`define DEAD_RESET      16'h07d0
`define UDIFF_RESET     16'h00c8
`define ANGLIM_RESET    16'h012c
`define FLIM_RESET      16'h000a
// force selections
`define FORCE_BLK1      3'h1
`define FORCE_OK1       3'h2
`define FORCE_BLK2      3'h3
`define FORCE_OK2       3'h4
`define FORCE_BLK3      3'h5
`define FORCE_OK3       3'h6
// side classes and voltage states
`define CLS_UNDEF       2'h0
`define CLS_DEAD        2'h1
`define CLS_LIVE        2'h2
`define VS_UNDEF        3'h4
`define VS_NOTMON       3'h5
`define PERM_BYPASS     4
// arithmetic: angle and frequency limits x10 to milli units, times in 5 ms units
`define LIM_SCALE       20'h0000a
`define ANG_HALF        21'h02bf20
`define ANG_FULL        32'h00057e40
`define ROT_NUM         32'h00030d40
`define ALIGN_MUL       32'h00000005
`define ALIGN_DIV       32'h00000009
`define TIME_MAX        32'h00011940
`define OBJ_ONE         5'h01
`endif

// ---- verilog/voltage_synchrocheck.v ----
// synchrocheck supervisor: registers, routing, forcing, switching
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "synchrocheck_defines.vh"
// Function
// - settings hidden and stages idle until an aux channel is in sync mode
// - each of three stages has an enable, off by default
// - stage runs always, or only while its start input is high
// - with forcing on, force a stage to blocked or ok; normal default
// - choose whether bus or line side is the measured side
// - stage one reference: none, phase pairs, phase-earth if wiring has them
// - stage two: none or phase pairs, only with both aux channels in use
// - stage three compares the aux pair, only in two-aux wiring mode
// - stage one alone may auto-close the breaker when synchronized
// - close is advanced by breaker time, 5 ms steps, default 50 ms
// - close goes to one of five objects, first by default
// - report estimated time left to closing, 5 ms units
// - report one full slip rotation time, 5 ms units
// - report present signed angle difference in millidegrees
// - setting changes act at once while supervision runs
// - permitted live/dead combinations or bypass; default live-live
// - side live above the live threshold, default 20 percent
// - side dead below dead threshold; zero threshold disables dead
// - magnitude difference must stay below its limit
// - angle difference must stay below its limit
// - frequency difference must stay below its limit
// - synchronized only when all three match and state is permitted
// - block sampled at cycle start; ok if clear, else blocked
// - block rising after ok clears ok
// - measurements refreshed every 5 ms
module voltage_synchrocheck #(
	parameter TICK_CYCLES = `MEAS_PERIOD_US * `CLK_FREQ_MHZ
) (
	// clock and reset
	input  wire                        clk,
	input  wire                        reset,
	// wishbone slave
	input  wire                        wb_cyc_i,
	input  wire                        wb_stb_i,
	input  wire                        wb_we_i,
	input  wire [7:0]                  wb_adr_i,
	input  wire [3:0]                  wb_sel_i,
	input  wire [31:0]                 wb_dat_i,
	output reg  [31:0]                 wb_dat_o,
	output reg                         wb_ack_o,
	// measurements, channel n in slice n
	input  wire [`NUM_CHAN*`MAG_W-1:0] measMag,
	input  wire [`NUM_CHAN*`ANG_W-1:0] measAng,
	input  wire [`NUM_CHAN*`FRQ_W-1:0] measFrq,
	// stage inputs
	input  wire [2:0]                  blockIn,
	input  wire [2:0]                  stageStart,
	// stage results and breaker close
	output reg  [2:0]                  stageOk,
	output reg  [2:0]                  stageBlocked,
	output reg  [4:0]                  closeCmd
);
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	function [`TIME_W-1:0] sat;
		input [31:0] x;
		reg   [31:0] capped;
		begin
			capped = (x > `TIME_MAX) ? `TIME_MAX : x;
			sat = capped[`TIME_W-1:0];
		end
	endfunction

	integer i;

	reg  [31:0]            ctrlQ;
	reg  [`REFSEL_W-1:0]   refSelQ;
	reg  [`TIME_W-1:0]     brkQ;
	reg  [`COND_W-1:0]     condQ   [0:2];
	reg  [`MAG_W-1:0]      liveQ   [0:2];
	reg  [`MAG_W-1:0]      deadQ   [0:2];
	reg  [`MAG_W-1:0]      uDiffQ  [0:2];
	reg  [`MAG_W-1:0]      angLimQ [0:2];
	reg  [`MAG_W-1:0]      fLimQ   [0:2];
	reg  [`MAG_W-1:0]      magQ    [0:`NUM_CHAN-1];
	reg  [`ANG_W-1:0]      angQ    [0:`NUM_CHAN-1];
	reg  [`FRQ_W-1:0]      frqQ    [0:`NUM_CHAN-1];
	reg  [`TICK_W-1:0]     tickCntQ;
	reg                    evalQ;
	reg                    statQ;
	reg                    firedQ;
	reg  [`TIME_W-1:0]     estQ;
	reg  [`TIME_W-1:0]     rotQ;
	reg  [2:0]             measIdx [0:2];
	reg  [2:0]             refIdx  [0:2];
	reg  [2:0]             forceBlk;
	reg  [2:0]             forceOk;
	reg  [31:0]            rdData;
	reg  [31:0]            remAng;
	wire [2:0]             okS;
	wire [2:0]             blkS;
	wire [2:0]             bypS;
	wire [2:0]             readyS;
	wire [8:0]             vsAll;
	wire [3*`ANG_W-1:0]    angAll;
	wire [3*`FRQ_W-1:0]    frqAll;
	wire [2:0]             avail;
	wire [2:0]             active;

	wire auxASs  = ctrlQ[`CTRL_AUXA_SS];
	wire auxBSs  = ctrlQ[`CTRL_AUXB_SS];
	wire anySs   = auxASs | auxBSs;
	wire bothSs  = auxASs & auxBSs;
	wire [2:0] ref1 = refSelQ[`REF1];
	wire [1:0] ref2 = refSelQ[`REF2];
	wire ref1Ok  = ref1 != `REF_NONE && (ref1 <= `REF_PP_LAST ||
		(ctrlQ[`CTRL_PE_AVAIL] && ref1 <= `REF_PE_LAST));
	wire tick    = tickCntQ == TICK_LAST[`TICK_W-1:0];

	assign avail[0] = anySs & ref1Ok;
	assign avail[1] = bothSs & (ref2 != 2'h0);
	assign avail[2] = bothSs & ctrlQ[`CTRL_TWO_AUX] & refSelQ[`REF3_BIT];
	assign active = avail & ctrlQ[`CTRL_EN_LSB +: 3] &
		(~ctrlQ[`CTRL_GATE_LSB +: 3] | stageStart);

	// measured channel and reference channel per stage
	always @* begin
		measIdx[0] = auxASs ? `CH_AUX_A : `CH_AUX_B;
		refIdx[0]  = ref1 - 3'h1;
		measIdx[1] = `CH_AUX_B;
		refIdx[1]  = {1'b0, ref2} - 3'h1;
		measIdx[2] = `CH_AUX_A;
		refIdx[2]  = `CH_AUX_B;
	end

	// measurement refresh period
	always @(posedge clk) begin
		if (reset) begin
			tickCntQ <= {`TICK_W{1'b0}};
			evalQ    <= 1'b0;
			statQ    <= 1'b0;
			for (i = 0; i < `NUM_CHAN; i = i + 1) begin
				magQ[i] <= {`MAG_W{1'b0}};
				angQ[i] <= {`ANG_W{1'b0}};
				frqQ[i] <= {`FRQ_W{1'b0}};
			end
		end else begin
			tickCntQ <= tick ? {`TICK_W{1'b0}} : tickCntQ + 1'b1;
			evalQ    <= tick;
			statQ    <= evalQ;
			if (tick)
				for (i = 0; i < `NUM_CHAN; i = i + 1) begin
					magQ[i] <= measMag[i*`MAG_W +: `MAG_W];
					angQ[i] <= measAng[i*`ANG_W +: `ANG_W];
					frqQ[i] <= measFrq[i*`FRQ_W +: `FRQ_W];
				end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : stg
			syn_stage u_stage (
				.clk        (clk),
				.reset      (reset),
				.evalTick   (evalQ),
				.active     (active[g]),
				.blockIn    (blockIn[g]),
				.lineIsMeas (ctrlQ[`CTRL_MEAS_LINE]),
				.condSel    (condQ[g]),
				.liveLim    (liveQ[g]),
				.deadLim    (deadQ[g]),
				.uDiffLim   (uDiffQ[g]),
				.angLim     (angLimQ[g]),
				.fLim       (fLimQ[g]),
				.measMag    (magQ[measIdx[g]]),
				.refMag     (magQ[refIdx[g]]),
				.measAng    (angQ[measIdx[g]]),
				.refAng     (angQ[refIdx[g]]),
				.measFrq    (frqQ[measIdx[g]]),
				.refFrq     (frqQ[refIdx[g]]),
				.ok         (okS[g]),
				.blocked    (blkS[g]),
				.bypass     (bypS[g]),
				.ready      (readyS[g]),
				.voltStat   (vsAll[g*3 +: 3]),
				.angDiff    (angAll[g*`ANG_W +: `ANG_W]),
				.frqDiff    (frqAll[g*`FRQ_W +: `FRQ_W])
			);
		end
	endgenerate

	// status forcing
	always @* begin
		forceBlk = 3'h0;
		forceOk  = 3'h0;
		if (ctrlQ[`CTRL_FORCE_EN]) begin
			case (ctrlQ[`CTRL_FORCE])
			`FORCE_BLK1: forceBlk = 3'h1;
			`FORCE_OK1:  forceOk  = 3'h1;
			`FORCE_BLK2: forceBlk = 3'h2;
			`FORCE_OK2:  forceOk  = 3'h2;
			`FORCE_BLK3: forceBlk = 3'h4;
			`FORCE_OK3:  forceOk  = 3'h4;
			default: forceBlk = 3'h0;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			stageOk      <= 3'h0;
			stageBlocked <= 3'h0;
		end else begin
			stageOk      <= (okS & ~forceBlk) | forceOk;
			stageBlocked <= (blkS & ~forceOk) | forceBlk;
		end
	end

	// synchronised switching on stage one
	wire signed [`ANG_W-1:0] ang1 = angAll[`ANG_W-1:0];
	wire signed [`FRQ_W-1:0] frq1 = frqAll[`FRQ_W-1:0];
	wire [`FRQ_W-1:0] absF = frq1[`FRQ_W-1] ? -frq1 : frq1;
	wire [31:0] ang32 = {{(32-`ANG_W){ang1[`ANG_W-1]}}, ang1};
	wire [31:0] absF32 = {{(32-`FRQ_W){1'b0}}, absF};
	wire fZero = absF == {`FRQ_W{1'b0}};
	wire [31:0] alignNum = remAng * `ALIGN_MUL;
	wire [31:0] alignDen = absF32 * `ALIGN_DIV;
	wire [`TIME_W-1:0] alignT = fZero ? sat(`TIME_MAX) :
		sat(alignNum / alignDen);
	wire [`TIME_W-1:0] rotT = fZero ? sat(`TIME_MAX) :
		sat(`ROT_NUM / absF32);

	// angle still to slip before the sides align
	always @(*) begin
		if (!frq1[`FRQ_W-1])
			remAng = ang1[`ANG_W-1] ? -ang32 : `ANG_FULL - ang32;
		else
			remAng = ang1[`ANG_W-1] ? `ANG_FULL + ang32 : ang32;
	end

	always @(posedge clk) begin
		if (reset) begin
			estQ     <= {`TIME_W{1'b0}};
			rotQ     <= {`TIME_W{1'b0}};
			firedQ   <= 1'b0;
			closeCmd <= 5'h00;
		end else begin
			closeCmd <= 5'h00;
			if (statQ) begin
				rotQ <= rotT;
				estQ <= (alignT > brkQ) ? alignT - brkQ
					: {`TIME_W{1'b0}};
				if (!readyS[0])
					firedQ <= 1'b0;
				else if (ctrlQ[`CTRL_SWITCH_EN] && !firedQ &&
					!blockIn[0] && (alignT <= brkQ || okS[0])) begin
					closeCmd <= `OBJ_ONE << ctrlQ[`CTRL_OBJ];
					firedQ   <= 1'b1;
				end
			end
		end
	end

	// wishbone slave
	wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire stgHit = wb_adr_i[`ADR_PAGE] == `PAGE_STAGE &&
		wb_adr_i[`ADR_STG] != `STG_NONE;
	wire [1:0] sIdx = wb_adr_i[`ADR_STG] - `STG_FIRST;
	wire [31:0] wrData = merge(rdData, wb_dat_i, wb_sel_i);

	always @* begin
		rdData = 32'h0;
		if (stgHit) begin
			if (anySs) begin
				case (wb_adr_i[`ADR_FLD])
				`STG_COND:  rdData = {{(32-`COND_W){1'b0}}, condQ[sIdx]};
				`STG_LEVEL: rdData = {deadQ[sIdx], liveQ[sIdx]};
				`STG_DIFF:  rdData = {angLimQ[sIdx], uDiffQ[sIdx]};
				default:    rdData = {{(32-`MAG_W){1'b0}}, fLimQ[sIdx]};
				endcase
			end
		end else begin
			case (wb_adr_i)
			`REG_CTRL:    rdData = ctrlQ;
			`REG_REFSEL:  if (anySs)
				rdData = {{(32-`REFSEL_W){1'b0}}, refSelQ};
			`REG_BRKTIME: if (anySs)
				rdData = {{(32-`TIME_W){1'b0}}, brkQ};
			`REG_STATUS:  rdData = {7'h0, vsAll, 1'b0, readyS, 1'b0, bypS,
				1'b0, stageBlocked, 1'b0, stageOk};
			`REG_ESTTIME: rdData = {{(32-`TIME_W){1'b0}}, estQ};
			`REG_ROTTIME: rdData = {{(32-`TIME_W){1'b0}}, rotQ};
			`REG_ANGLE:   rdData = ang32;
			default:      rdData = 32'h0;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wbReq;
			if (wbReq && !wb_we_i)
				wb_dat_o <= rdData;
		end
	end

	// settings are live: a write steers the next evaluation
	always @(posedge clk) begin
		if (reset) begin
			ctrlQ   <= `CTRL_RESET;
			refSelQ <= `REFSEL_RESET;
			brkQ    <= `BRK_RESET;
			for (i = 0; i < 3; i = i + 1) begin
				condQ[i]   <= `COND_RESET;
				liveQ[i]   <= `LIVE_RESET;
				deadQ[i]   <= `DEAD_RESET;
				uDiffQ[i]  <= `UDIFF_RESET;
				angLimQ[i] <= `ANGLIM_RESET;
				fLimQ[i]   <= `FLIM_RESET;
			end
		end else if (wbReq && wb_we_i) begin
			if (wb_adr_i == `REG_CTRL)
				ctrlQ <= wrData & `CTRL_MASK;
			else if (anySs) begin
				if (wb_adr_i == `REG_REFSEL)
					refSelQ <= wrData[`REFSEL_W-1:0];
				else if (wb_adr_i == `REG_BRKTIME)
					brkQ <= wrData[`TIME_W-1:0];
				else if (stgHit) begin
					case (wb_adr_i[`ADR_FLD])
					`STG_COND: condQ[sIdx] <= wrData[`COND_W-1:0];
					`STG_LEVEL: begin
						liveQ[sIdx] <= wrData[`LO_HALF];
						deadQ[sIdx] <= wrData[`HI_HALF];
					end
					`STG_DIFF: begin
						uDiffQ[sIdx]  <= wrData[`LO_HALF];
						angLimQ[sIdx] <= wrData[`HI_HALF];
					end
					default: fLimQ[sIdx] <= wrData[`LO_HALF];
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire
